// [rtl/lcc_consts.vh]
// offsets, field positions, reset values and sizes for the logic cell cascade
`ifndef LCC_CONSTS_VH
`define LCC_CONSTS_VH
`define LCC_CELLS_PER_CLUSTER 10
`define LCC_NUM_CLUSTERS 4
`define LCC_LUT_INPUTS 4
`define LCC_CFG_BASE 12'h000
`define LCC_STAT_BASE 12'h400
`define LCC_CFG_RESET 32'h0000_0000
`define LCC_F_MASK_LO 0
`define LCC_F_MASK_HI 15
`define LCC_F_MODE_LO 16
`define LCC_F_MODE_HI 17
`define LCC_F_BYPASS 18
`define LCC_F_CLK_LO 19
`define LCC_F_CLK_HI 20
`define LCC_F_CLR_LO 21
`define LCC_F_CLR_HI 22
`define LCC_F_LINK 23
`define LCC_F_OR 24
`define LCC_F_SRC_LO 25
`define LCC_F_SRC_HI 30
`define LCC_MODE_D 2'h0
`define LCC_MODE_T 2'h1
`define LCC_MODE_JK 2'h2
`define LCC_MODE_SR 2'h3
`define LCC_CLK_GLOBAL 2'h0
`define LCC_CLK_PIN 2'h1
`define LCC_CLK_INTERNAL 2'h2
`define LCC_CLR_NONE 2'h0
`define LCC_CLR_GLOBAL 2'h1
`define LCC_CLR_PIN 2'h2
`define LCC_CLR_INTERNAL 2'h3
`endif

// [rtl/lcc_cell.v]
// one logic cell: table, cascade stage and configurable storage element
`include "lcc_consts.vh"
module lcc_cell (
  input wire clk,
  input wire rst_n,
  input wire [31:0] cfg,
  input wire [3:0] data_in,
  input wire chain_in,
  input wire clk_src,
  input wire clr_src,
  output wire lut_out,
  output wire chain_out,
  output wire cell_out,
  output wire q_out
);
  reg q_r;
  reg q_nxt;
  reg src_prev_r;
  wire [15:0] mask;
  wire [1:0] mode;
  wire or_op;
  wire cin;
  wire tick;
  wire k_in;

  assign mask = cfg[`LCC_F_MASK_HI:`LCC_F_MASK_LO];
  assign mode = cfg[`LCC_F_MODE_HI:`LCC_F_MODE_LO];
  assign or_op = cfg[`LCC_F_OR];
  assign lut_out = mask[data_in];
  // unlinked head of chain sees identity value
  assign cin = cfg[`LCC_F_LINK] ? chain_in : ~or_op;
  // and, or or through inverted and
  assign chain_out = or_op ? ~(~lut_out & ~cin) : (lut_out & cin);
  // rising edge of the selected clock source
  assign tick = clk_src & ~src_prev_r;
  assign k_in = data_in[3];

  // d, t, jk or sr behaviour
  always @* begin
    q_nxt = q_r;
    case (mode)
      `LCC_MODE_D: q_nxt = chain_out;
      `LCC_MODE_T: q_nxt = q_r ^ chain_out;
      `LCC_MODE_JK: q_nxt = (chain_out & ~q_r) | (~k_in & q_r);
      `LCC_MODE_SR: q_nxt = (chain_out & ~k_in) ? 1'b1 : ((~chain_out & k_in) ? 1'b0 : q_r);
      default: q_nxt = q_r;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      q_r <= 1'b0;
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= clk_src;
      // selected clear wins over selected clock
      if (clr_src)
        q_r <= 1'b0;
      else if (tick)
        q_r <= q_nxt;
    end
  end

  // bypass passes the cascade result straight out
  assign cell_out = cfg[`LCC_F_BYPASS] ? chain_out : q_r;
  assign q_out = q_r;
endmodule

// [rtl/lcc_top.v]
// cascaded logic cell array with apb configuration registers
//
// The address map and the APB interface to the registers were left to the implementer.
`include "lcc_consts.vh"
module lcc_top #(
  parameter CELLS_PER_CLUSTER = `LCC_CELLS_PER_CLUSTER,
  parameter NUM_CLUSTERS = `LCC_NUM_CLUSTERS
) (
  input wire CORE_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [NUM_CLUSTERS*CELLS_PER_CLUSTER*4-1:0] CELL_DATA,
  input wire GLOBAL_CLK,
  input wire GLOBAL_CLR,
  input wire PIN_CLK,
  input wire PIN_CLR,
  output reg [NUM_CLUSTERS*CELLS_PER_CLUSTER-1:0] LOCAL_ROUTE,
  output reg [NUM_CLUSTERS*CELLS_PER_CLUSTER-1:0] CLUSTER_ROUTE,
  output reg [NUM_CLUSTERS*CELLS_PER_CLUSTER-1:0] ROWCOL_ROUTE,
  output reg [NUM_CLUSTERS-1:0] CLUSTER_CHAIN_OUT
);
  // cells in the whole array
  localparam NCELL = NUM_CLUSTERS * CELLS_PER_CLUSTER;

  reg [31:0] cfg_r [0:NCELL-1];
  wire [NCELL-1:0] lut_w;
  wire [NCELL-1:0] chain_w;
  wire [NCELL-1:0] out_w;
  wire [NCELL-1:0] q_w;
  wire [NCELL-1:0] cin_w;
  wire [NCELL-1:0] csrc_w;
  wire [NCELL-1:0] rsrc_w;
  wire [NUM_CLUSTERS-1:0] last_chain_w;
  reg [31:0] rdata_nxt;
  reg err_nxt;
  wire setup;
  wire access;
  wire cfg_hit;
  wire sts_hit;
  wire cfg_we;
  integer cfg_idx;
  integer sts_idx;
  integer i;

  // word index into either register group; -1 means unmapped
  function integer cell_index;
    input [11:0] addr;
    input [11:0] base;
    begin
      if (addr[1:0] == 2'h0 && addr >= base && ((addr - base) >> 2) < NCELL)
        cell_index = (addr - base) >> 2;
      else
        cell_index = -1;
    end
  endfunction

  // status word of one cell: table, chain, cell output and stored bit
  function [31:0] status_word;
    input q;
    input out;
    input chain;
    input lut;
    begin
      status_word = {28'h0000000, q, out, chain, lut};
    end
  endfunction

  // clock source multiplexer, also used for clear with its own encoding
  function pick_src;
    input [1:0] sel;
    input glob;
    input pin;
    input intl;
    input with_none;
    begin
      if (with_none)
        case (sel)
          `LCC_CLR_GLOBAL: pick_src = glob;
          `LCC_CLR_PIN: pick_src = pin;
          `LCC_CLR_INTERNAL: pick_src = intl;
          default: pick_src = 1'b0;
        endcase
      else
        case (sel)
          `LCC_CLK_GLOBAL: pick_src = glob;
          `LCC_CLK_PIN: pick_src = pin;
          `LCC_CLK_INTERNAL: pick_src = intl;
          default: pick_src = 1'b0;
        endcase
    end
  endfunction

  // one cell per position, clusters laid out one after another
  genvar g;
  generate
    for (g = 0; g < NCELL; g = g + 1) begin : cells
      wire [5:0] src_idx;
      wire intl;
      assign src_idx = cfg_r[g][`LCC_F_SRC_HI:`LCC_F_SRC_LO];
      // an index past the array reads as a quiet source
      assign intl = (src_idx < NCELL) ? out_w[src_idx] : 1'b0;
      // per-cell clock and clear source selection
      assign csrc_w[g] = pick_src(cfg_r[g][`LCC_F_CLK_HI:`LCC_F_CLK_LO],
                                  GLOBAL_CLK, PIN_CLK, intl, 1'b0);
      assign rsrc_w[g] = pick_src(cfg_r[g][`LCC_F_CLR_HI:`LCC_F_CLR_LO],
                                  GLOBAL_CLR, PIN_CLR, intl, 1'b1);
      if (g % CELLS_PER_CLUSTER != 0) begin : inner
        // next cell in cluster extends chain by four inputs
        assign cin_w[g] = chain_w[g-1];
      end else if (g / CELLS_PER_CLUSTER >= 2) begin : hop
        // enter first cell from the cluster two places back (clusters 2 and up)
        // last cell of the cluster two places back
        localparam PRED = g - CELLS_PER_CLUSTER - 1;
        assign cin_w[g] = chain_w[PRED];
      end else begin : head
        // no predecessor; head sees the identity of its own operation
        assign cin_w[g] = ~cfg_r[g][`LCC_F_OR];
      end
      lcc_cell u_cell (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .cfg(cfg_r[g]),
        .data_in(CELL_DATA[4*g+3:4*g]),
        .chain_in(cin_w[g]),
        .clk_src(csrc_w[g]),
        .clr_src(rsrc_w[g]),
        .lut_out(lut_w[g]),
        .chain_out(chain_w[g]),
        .cell_out(out_w[g]),
        .q_out(q_w[g])
      );
    end
    // chain value where it leaves each cluster
    for (g = 0; g < NUM_CLUSTERS; g = g + 1) begin : tails
      assign last_chain_w[g] = chain_w[g*CELLS_PER_CLUSTER + CELLS_PER_CLUSTER - 1];
    end
  endgenerate

  // setup and completing access phases of a transfer
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & PREADY;

  // word index of the address in each register group, -1 when outside
  always @* begin
    cfg_idx = cell_index(PADDR, `LCC_CFG_BASE);
    sts_idx = cell_index(PADDR, `LCC_STAT_BASE);
  end

  assign cfg_hit = (cfg_idx >= 0);
  assign sts_hit = (sts_idx >= 0);
  // a write lands only at the access edge, never when refused at setup
  assign cfg_we = access & PWRITE & ~PSLVERR & cfg_hit;

  // read data and error decided in the setup cycle
  always @* begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b1;
    if (cfg_hit) begin
      rdata_nxt = cfg_r[cfg_idx];
      err_nxt = 1'b0;
    end else if (sts_hit) begin
      rdata_nxt = status_word(q_w[sts_idx], out_w[sts_idx], chain_w[sts_idx], lut_w[sts_idx]);
      // status is read only, so a write there is refused
      err_nxt = PWRITE;
    end
  end

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      // every cell starts empty: d mode on the global clock, no clear
      for (i = 0; i < NCELL; i = i + 1)
        cfg_r[i] <= `LCC_CFG_RESET;
    end else begin
      // no wait states: ready follows every setup cycle
      PREADY <= setup;
      if (setup) begin
        // a write setup leaves zero on the read bus
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata_nxt;
        PSLVERR <= err_nxt;
      end else if (access) begin
        // error stands only through the access cycle
        PSLVERR <= 1'b0;
      end
      if (cfg_we)
        cfg_r[cfg_idx] <= PWDATA;
    end
  end

  // every cell output drives all three routing levels at once
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      LOCAL_ROUTE <= {NCELL{1'b0}};
      CLUSTER_ROUTE <= {NCELL{1'b0}};
      ROWCOL_ROUTE <= {NCELL{1'b0}};
      CLUSTER_CHAIN_OUT <= {NUM_CLUSTERS{1'b0}};
    end else begin
      LOCAL_ROUTE <= out_w;
      CLUSTER_ROUTE <= out_w;
      ROWCOL_ROUTE <= out_w;
      CLUSTER_CHAIN_OUT <= last_chain_w;
    end
  end
endmodule

// [verification/lcc_checker.sv]
// apb timing, refusal and routing copy checks for the cell array
module lcc_checker #(
  parameter NUM_CLUSTERS = 4,
  parameter CELLS_PER_CLUSTER = 10
) (
  input wire CORE_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [NUM_CLUSTERS*CELLS_PER_CLUSTER-1:0] LOCAL_ROUTE,
  input wire [NUM_CLUSTERS*CELLS_PER_CLUSTER-1:0] CLUSTER_ROUTE,
  input wire [NUM_CLUSTERS*CELLS_PER_CLUSTER-1:0] ROWCOL_ROUTE
);
  localparam int B = NUM_CLUSTERS * CELLS_PER_CLUSTER * 4;
  wire su = PSEL && !PENABLE;
  wire st = PADDR >= 12'h400;
  wire ok = PADDR[1:0] == 2'h0 && (PADDR < B || st && PADDR < 12'h400 + B);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_rdy; su |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_one; PREADY |-> $past(su); endproperty
  a_one: assert property (p_one) else $error("ready without setup");
  property p_pls; PREADY |=> !PREADY; endproperty
  a_pls: assert property (p_pls) else $error("ready longer than one cycle");
  property p_hold; PREADY |=> $stable(PRDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved after access");
  property p_bad; su && !ok |=> PSLVERR && PREADY; endproperty
  a_bad: assert property (p_bad) else $error("bad address not refused");
  property p_zero; su && !ok && !PWRITE |=> PRDATA == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("bad address read not zero");
  property p_sts; su && ok && st && PWRITE |=> PSLVERR; endproperty
  a_sts: assert property (p_sts) else $error("status write not refused");
  property p_good; su && ok && !(st && PWRITE) |=> !PSLVERR; endproperty
  a_good: assert property (p_good) else $error("legal access refused");
  property p_rt; CLUSTER_ROUTE == LOCAL_ROUTE && ROWCOL_ROUTE == LOCAL_ROUTE; endproperty
  a_rt: assert property (p_rt) else $error("routing copies differ");
endmodule
bind lcc_top lcc_checker #(.NUM_CLUSTERS(NUM_CLUSTERS), .CELLS_PER_CLUSTER(CELLS_PER_CLUSTER))
  lcc_checker_i (.*);

// [verification/lcc_nbr.sv]
// neighbour model: routing fabric driving table inputs and clock/clear sources
module lcc_nbr (
  input wire clk,
  input wire [159:0] dreq,
  input wire [3:0] sreq,
  output logic [159:0] cell_data,
  output logic [3:0] src
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) {cell_data, src} <= {dreq, sreq};
endmodule

// [verification/lcc_tb.sv]
// testbench: apb config, table, cascade and storage checks against a model
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err, rdy, ev, cl, q = 0;
  logic [11:0] pa = 0, bad [4] = '{12'h0a0, 12'h002, 12'h3fc, 12'hffc};
  logic [31:0] pwd = 0, prd, rv, n, cfg [40] = '{default: 0};
  logic [159:0] dreq = '0, cd;
  logic [3:0] sreq = 0, src, cco;
  logic [39:0] lr, cr, rr;
  integer n_fail = 0, compares = 0, seed = 32'h0f4d, cyc = 0, i, k, m, s;
  lcc_nbr lcc_nbr_i (.clk(clk), .dreq(dreq), .sreq(sreq), .cell_data(cd), .src(src));
  lcc_top lcc_top_i (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .CELL_DATA(cd), .GLOBAL_CLK(src[0]), .PIN_CLK(src[1]), .GLOBAL_CLR(src[2]),
    .PIN_CLR(src[3]), .LOCAL_ROUTE(lr), .CLUSTER_ROUTE(cr), .ROWCOL_ROUTE(rr),
    .CLUSTER_CHAIN_OUT(cco));
  initial forever #5 clk = ~clk;
  task close_out;
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  task chk(input logic [32:0] g, e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rv = prd; ev = err;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask
  task wr(input int c, input logic [31:0] d);
    cfg[c] = d;
    apb(1, 12'(4 * c), d);
    apb(0, 12'(4 * c), 0);
    chk({ev, rv}, {1'b0, d});
  endtask
  function automatic logic lut(int c);
    return cfg[c][dreq[4*c+:4]];
  endfunction
  function automatic logic chn(int c);
    logic ci;
    ci = !cfg[c][24];
    if (cfg[c][23] && (c % 10 != 0 || c >= 20)) ci = chn(c % 10 != 0 ? c - 1 : c - 11);
    return cfg[c][24] ? lut(c) | ci : lut(c) & ci;
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h49c, 0);
    chk({ev, rv}, 0);
    for (i = 0; i < 5; i++) begin
      apb(1, i < 4 ? bad[i] : 12'h400, '1);
      chk(ev, 1);
      apb(0, i < 4 ? bad[i] : 12'h000, 0);
      chk({ev, rv}, {i < 4, 32'h0});
    end
    for (k = 0; k < 6; k++) begin
      for (i = 0; i < 5; i++) dreq[32*i+:32] <= $random(seed);
      for (i = 0; i < 20; i++)
        wr(i + i / 10 * 10, {7'h0, k[0], 1'(i != 0 || k[1]), 7'h4, 16'($random(seed))});
      repeat (2) @(posedge clk);
      chk(cco, {chn(39), chn(29), chn(19), chn(9)});
      chk(lr[0], lut(0));
      apb(0, 12'h474, 0);
      chk(rv[1:0], {chn(29), lut(29)});
    end
    dreq[123] <= 0;
    wr(30, 32'h0004_ff00);
    for (k = 0; k < 24; k++) begin
      m = k % 4; s = k / 4 % 3; cl = k % 7 == 6;
      wr(5, {1'b0, 6'd30, 2'h0, 2'h2, 2'(s), 1'b0, 2'(m), 16'haaaa});
      n = $random(seed);
      dreq[23:20] <= n[3:0]; sreq <= {cl, n[1], 2'h0};
      repeat (3) @(posedge clk);
      if (s == 2) dreq[123] <= 1;
      else sreq[s] <= 1;
      repeat (3) @(posedge clk);
      if (s == 2) dreq[123] <= 0;
      else sreq[s] <= 0;
      if (cl) q = 0;
      else if (m == 0) q = n[0];
      else if (m == 1) q = q ^ n[0];
      else if (m == 2) q = n[0] & !q | !n[3] & q;
      else q = n[0] ^ n[3] ? n[0] : q;
      repeat (3) @(posedge clk);
      chk(lr[5], q);
    end
    close_out;
  end
endmodule
